// ### shared/cacs_pkg.sv
// Constants and types for the configuration, address, checksum and fault simulation block.
// Assumes a PMBus protocol engine outside that decodes transactions into command strobes.
package cacs_pkg;
    // Command codes
    localparam logic [7:0] CMD_OVERRIDE = 8'hee;
    localparam logic [7:0] CMD_ADDR = 8'hef;
    localparam logic [7:0] CMD_CRC = 8'hf0;
    localparam logic [7:0] CMD_SIM = 8'hf1;

    // Strap override selection bits
    localparam int OVR_OUTPUT_VOLTAGE_SOURCE_BIT = 0;
    localparam int OVR_SWITCHING_RATE_SOURCE_BIT = 1;
    localparam int OVR_OC_BIT = 2;
    localparam logic [15:0] OVR_RESET = 16'h0000;

    // Target address
    localparam int ADDR_W = 7;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_RSVD_0 = 7'h0c;
    localparam logic [ADDR_W-1:0] ADDR_RSVD_1 = 7'h28;
    localparam logic [ADDR_W-1:0] ADDR_RSVD_2 = 7'h37;
    localparam logic [ADDR_W-1:0] ADDR_RSVD_3 = 7'h61;

    // Settings checksum
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam int NVM_AW = 5;
    localparam logic [NVM_AW-1:0] NVM_LAST = 5'h1f;

    // Fault simulation word
    localparam int NUM_PHASES = 4;
    localparam int PHASE_W = 2;
    localparam int SIM_FAULT_HOLD = 15;
    localparam int SIM_OVERTEMP_FAULT = 14;
    localparam int SIM_OVERCURRENT_FAULT = 12;
    localparam int SIM_INPUT_LOCKOUT = 11;
    localparam int SIM_INPUT_OVERVOLTAGE_FAULT = 10;
    localparam int SIM_OUTPUT_UNDERVOLTAGE_FAULT = 9;
    localparam int SIM_OUTPUT_OVERVOLTAGE_FAULT = 8;
    localparam int SIM_WARN_HOLD = 7;
    localparam int SIM_OVERCURRENT_WARNING = 4;
    localparam int SIM_INPUT_UNDERVOLTAGE_WARNING = 3;
    localparam int SIM_OUTPUT_UNDERVOLTAGE_WARNING = 1;
    localparam int SIM_OUTPUT_OVERVOLTAGE_WARNING = 0;
    localparam logic [15:0] SIM_RESET = 16'h0000;
    localparam logic [15:0] SIM_FAULT_MASK = 16'h5f00;
    localparam logic [15:0] SIM_WARN_MASK = 16'h001b;
    localparam logic [15:0] SIM_OFFCONV_MASK = 16'h0900;

    typedef logic [NUM_PHASES-1:0][15:0] cacs_sim_t;
endpackage : cacs_pkg

// ### shared/cacs_crc_if.sv
// Link between the register block and its settings checksum engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cacs_crc_if;
    import cacs_pkg::*;
    logic start;
    logic busy;
    logic [15:0] result;
    logic [NVM_AW-1:0] rd_addr;
    logic [15:0] rd_data;

    modport mgr (output start, output rd_data, input busy, input result, input rd_addr);
    modport eng (input start, input rd_data, output busy, output result, output rd_addr);
endinterface : cacs_crc_if

// ### hw/cacs_crc.sv
// Settings checksum engine: CRC-16 over the stored settings words.
// Assumes settings memory returns the word one clock after the address.
`timescale 1ns/1ps
module cacs_crc
    import cacs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    cacs_crc_if.eng bus
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_FOLD} cacs_crc_st_e;

    typedef struct packed {
        cacs_crc_st_e st;
        logic [NVM_AW-1:0] addr;
        logic [15:0] crc;
        logic [15:0] result;
        logic busy;
    } cacs_crc_s;

    cacs_crc_s s_q;
    cacs_crc_s s_d;

    function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            fb = r[15] ^ w[i];
            r = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction : crc_word

    always_comb begin
        s_d = s_q;
        // A new request restarts the walk from the first word
        if (bus.start) begin
            s_d.st = ST_FETCH;
            s_d.addr = '0;
            s_d.crc = CRC_INIT;
        end else begin
            unique case (s_q.st)
                ST_IDLE: begin
                end
                ST_FETCH: begin
                    s_d.st = ST_FOLD;
                end
                ST_FOLD: begin
                    s_d.crc = crc_word(s_q.crc, bus.rd_data);
                    if (s_q.addr == NVM_LAST) begin
                        s_d.result = crc_word(s_q.crc, bus.rd_data);
                        s_d.st = ST_IDLE;
                    end else begin
                        s_d.addr = s_q.addr + 1'b1;
                        s_d.st = ST_FETCH;
                    end
                end
            endcase
        end
        // Busy kept in a flop so the top output has no logic behind it
        s_d.busy = (s_d.st != ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{st: ST_IDLE, addr: '0, crc: CRC_INIT, result: CRC_INIT, busy: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.busy = s_q.busy;
    assign bus.result = s_q.result;
    assign bus.rd_addr = s_q.addr;
endmodule : cacs_crc

// ### hw/cacs_top.sv
// Manufacturer configuration registers: strap override, target address,
// settings checksum and per-phase fault simulation.
// Assumes an outside protocol engine that decodes bus transactions into command
// strobes, settings memory with one-clock read latency, and strap values held stable.
`timescale 1ns/1ps
module cacs_top
    import cacs_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic CMD_WORD,
    input wire logic [7:0] CMD_CODE,
    input wire logic [PHASE_W-1:0] CMD_PHASE,
    input wire logic [15:0] CMD_WDATA,
    output logic [15:0] CMD_RDATA,
    output logic CMD_RVALID,
    output logic CMD_NACK,
    input wire logic ADDR_STROBE,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    output logic ADDR_ACK,
    output logic ADDR_NACK,
    input wire logic RESTORE_REQ,
    input wire logic STORE_DONE,
    input wire logic [15:0] NVM_OVERRIDE,
    input wire logic [ADDR_W-1:0] NVM_ADDR,
    output logic [NVM_AW-1:0] NVM_RADDR,
    input wire logic [15:0] NVM_RDATA,
    output logic CRC_BUSY,
    input wire logic [15:0] PIN_OC_FAULT,
    input wire logic [15:0] NVM_OC_FAULT,
    input wire logic [15:0] PIN_OC_WARN,
    input wire logic [15:0] NVM_OC_WARN,
    input wire logic [15:0] PIN_SW_RATE,
    input wire logic [15:0] NVM_SW_RATE,
    input wire logic [15:0] PIN_OUTPUT_VOLTAGE_SOURCE_TARGET,
    input wire logic [15:0] NVM_OUTPUT_VOLTAGE_SOURCE_TARGET,
    input wire logic [15:0] PIN_LOOP_SCALE,
    input wire logic [15:0] NVM_LOOP_SCALE,
    input wire logic [15:0] PIN_OUTPUT_VOLTAGE_SOURCE_CEIL,
    input wire logic [15:0] NVM_OUTPUT_VOLTAGE_SOURCE_CEIL,
    input wire logic [15:0] PIN_OUTPUT_VOLTAGE_SOURCE_FLOOR,
    input wire logic [15:0] NVM_OUTPUT_VOLTAGE_SOURCE_FLOOR,
    output logic [15:0] OVERCURRENT_FAULT_THRESHOLD,
    output logic [15:0] OVERCURRENT_WARNING_THRESHOLD,
    output logic [15:0] SWITCHING_RATE,
    output logic [15:0] OUTPUT_VOLTAGE_TARGET,
    output logic [15:0] OUTPUT_LOOP_SCALE,
    output logic [15:0] OUTPUT_VOLTAGE_CEILING,
    output logic [15:0] OUTPUT_VOLTAGE_FLOOR,
    input wire logic CONV_EN,
    input wire logic [NUM_PHASES-1:0] FAULT_RESP,
    input wire logic [NUM_PHASES-1:0] WARN_RESP,
    output cacs_sim_t SIM_FORCE
);
    typedef enum logic [0:0] {ST_BOOT, ST_RUN} cacs_st_e;

    typedef struct packed {
        cacs_st_e st;
        logic [15:0] override;
        logic [ADDR_W-1:0] addr;
        cacs_sim_t sim;
        cacs_sim_t force_out;
        logic [15:0] oc_fault;
        logic [15:0] oc_warn;
        logic [15:0] sw_rate;
        logic [15:0] output_voltage_source_target;
        logic [15:0] loop_scale;
        logic [15:0] output_voltage_source_ceil;
        logic [15:0] output_voltage_source_floor;
        logic [15:0] rdata;
        logic rvalid;
        logic nack;
        logic addr_ack;
        logic addr_nack;
        logic crc_start;
    } cacs_top_s;

    cacs_top_s s_q;
    cacs_top_s s_d;

    cacs_crc_if crc_bus ();

    cacs_crc u_crc (
        .clk(SYS_CLK),
        .rst(RST),
        .bus(crc_bus)
    );

    assign crc_bus.start = s_q.crc_start;
    assign crc_bus.rd_data = NVM_RDATA;

    function automatic logic addr_reserved(input logic [ADDR_W-1:0] a);
        return (a == ADDR_RSVD_0) || (a == ADDR_RSVD_1) ||
            (a == ADDR_RSVD_2) || (a == ADDR_RSVD_3);
    endfunction : addr_reserved

    logic [15:0] live_mask;

    always_comb begin
        // Disabled conversion lets only lockout and output OV through
        live_mask = CONV_EN ? (SIM_FAULT_MASK | SIM_WARN_MASK) : SIM_OFFCONV_MASK;

        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.nack = 1'b0;
        s_d.addr_ack = 1'b0;
        s_d.addr_nack = 1'b0;
        s_d.crc_start = 1'b0;

        // Power-up load and restore of user settings
        if ((s_q.st == ST_BOOT) || RESTORE_REQ) begin
            s_d.st = ST_RUN;
            s_d.override = NVM_OVERRIDE;
            if (!addr_reserved(NVM_ADDR)) begin
                s_d.addr = NVM_ADDR;
            end
            if (NVM_OVERRIDE[OVR_OC_BIT]) begin
                s_d.oc_fault = PIN_OC_FAULT;
                s_d.oc_warn = PIN_OC_WARN;
            end else begin
                s_d.oc_fault = NVM_OC_FAULT;
                s_d.oc_warn = NVM_OC_WARN;
            end
            s_d.sw_rate = NVM_OVERRIDE[OVR_SWITCHING_RATE_SOURCE_BIT] ? PIN_SW_RATE : NVM_SW_RATE;
            if (NVM_OVERRIDE[OVR_OUTPUT_VOLTAGE_SOURCE_BIT]) begin
                s_d.output_voltage_source_target = PIN_OUTPUT_VOLTAGE_SOURCE_TARGET;
                s_d.loop_scale = PIN_LOOP_SCALE;
                s_d.output_voltage_source_ceil = PIN_OUTPUT_VOLTAGE_SOURCE_CEIL;
                s_d.output_voltage_source_floor = PIN_OUTPUT_VOLTAGE_SOURCE_FLOOR;
            end else begin
                s_d.output_voltage_source_target = NVM_OUTPUT_VOLTAGE_SOURCE_TARGET;
                s_d.loop_scale = NVM_LOOP_SCALE;
                s_d.output_voltage_source_ceil = NVM_OUTPUT_VOLTAGE_SOURCE_CEIL;
                s_d.output_voltage_source_floor = NVM_OUTPUT_VOLTAGE_SOURCE_FLOOR;
            end
            s_d.crc_start = 1'b1;
        end
        if (STORE_DONE) begin
            s_d.crc_start = 1'b1;
        end

        // Address phase compare uses the live register, so a change acts at once
        if (ADDR_STROBE) begin
            s_d.addr_ack = (ADDR_IN == s_q.addr);
            s_d.addr_nack = (ADDR_IN != s_q.addr);
        end

        // One response removes simulated conditions unless held
        for (int p = 0; p < NUM_PHASES; p++) begin
            if (FAULT_RESP[p] && !s_q.sim[p][SIM_FAULT_HOLD]) begin
                s_d.sim[p] = s_d.sim[p] & ~SIM_FAULT_MASK;
            end
            if (WARN_RESP[p] && !s_q.sim[p][SIM_WARN_HOLD]) begin
                s_d.sim[p] = s_d.sim[p] & ~SIM_WARN_MASK;
            end
        end

        // Command decode; a write in the same cycle wins over an auto-clear
        if (CMD_VALID) begin
            unique case (CMD_CODE)
                CMD_OVERRIDE: begin
                    if (!CMD_WORD) begin
                        s_d.nack = 1'b1;
                    end else if (CMD_WRITE) begin
                        s_d.override = CMD_WDATA;
                    end else begin
                        s_d.rdata = s_q.override;
                        s_d.rvalid = 1'b1;
                    end
                end
                CMD_ADDR: begin
                    if (CMD_WORD) begin
                        s_d.nack = 1'b1;
                    end else if (CMD_WRITE) begin
                        if (!addr_reserved(CMD_WDATA[ADDR_W-1:0])) begin
                            s_d.addr = CMD_WDATA[ADDR_W-1:0];
                        end
                    end else begin
                        s_d.rdata = {8'h00, 1'b0, s_q.addr};
                        s_d.rvalid = 1'b1;
                    end
                end
                CMD_CRC: begin
                    if (CMD_WRITE || !CMD_WORD) begin
                        s_d.nack = 1'b1;
                    end else begin
                        s_d.rdata = crc_bus.result;
                        s_d.rvalid = 1'b1;
                    end
                end
                CMD_SIM: begin
                    if (!CMD_WORD) begin
                        s_d.nack = 1'b1;
                    end else if (CMD_WRITE) begin
                        s_d.sim[CMD_PHASE] = CMD_WDATA;
                    end else begin
                        s_d.rdata = s_q.sim[CMD_PHASE];
                        s_d.rvalid = 1'b1;
                    end
                end
                default: begin
                    s_d.nack = 1'b1;
                end
            endcase
        end

        // Forced detector outputs per phase, reserved and hold bits never force
        for (int p = 0; p < NUM_PHASES; p++) begin
            s_d.force_out[p] = s_q.sim[p] & live_mask;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            s_q <= '{
                st: ST_BOOT,
                override: OVR_RESET,
                addr: ADDR_RESET,
                sim: {NUM_PHASES{SIM_RESET}},
                force_out: {NUM_PHASES{SIM_RESET}},
                oc_fault: 16'h0000,
                oc_warn: 16'h0000,
                sw_rate: 16'h0000,
                output_voltage_source_target: 16'h0000,
                loop_scale: 16'h0000,
                output_voltage_source_ceil: 16'h0000,
                output_voltage_source_floor: 16'h0000,
                rdata: 16'h0000,
                rvalid: 1'b0,
                nack: 1'b0,
                addr_ack: 1'b0,
                addr_nack: 1'b0,
                crc_start: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign CMD_RDATA = s_q.rdata;
    assign CMD_RVALID = s_q.rvalid;
    assign CMD_NACK = s_q.nack;
    assign ADDR_ACK = s_q.addr_ack;
    assign ADDR_NACK = s_q.addr_nack;
    assign NVM_RADDR = crc_bus.rd_addr;
    assign CRC_BUSY = crc_bus.busy;
    assign OVERCURRENT_FAULT_THRESHOLD = s_q.oc_fault;
    assign OVERCURRENT_WARNING_THRESHOLD = s_q.oc_warn;
    assign SWITCHING_RATE = s_q.sw_rate;
    assign OUTPUT_VOLTAGE_TARGET = s_q.output_voltage_source_target;
    assign OUTPUT_LOOP_SCALE = s_q.loop_scale;
    assign OUTPUT_VOLTAGE_CEILING = s_q.output_voltage_source_ceil;
    assign OUTPUT_VOLTAGE_FLOOR = s_q.output_voltage_source_floor;
    assign SIM_FORCE = s_q.force_out;
endmodule : cacs_top

// ### tb/cacs_chk.sv
// Port-level checker for the configuration register block.
// Assumes binding into cacs_top, one clock, synchronous active-high reset.
`timescale 1ns/1ps
module cacs_chk
    import cacs_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic CMD_WORD,
    input wire logic [7:0] CMD_CODE,
    input wire logic [PHASE_W-1:0] CMD_PHASE,
    input wire logic [15:0] CMD_WDATA,
    input wire logic [15:0] CMD_RDATA,
    input wire logic CMD_RVALID,
    input wire logic CMD_NACK,
    input wire logic ADDR_STROBE,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic ADDR_ACK,
    input wire logic ADDR_NACK,
    input wire logic RESTORE_REQ,
    input wire logic STORE_DONE,
    input wire logic CRC_BUSY,
    input wire logic CONV_EN,
    input wire logic [NUM_PHASES-1:0] FAULT_RESP,
    input wire logic [NUM_PHASES-1:0] WARN_RESP,
    input wire cacs_sim_t SIM_FORCE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    function automatic logic is_rsvd(input logic [ADDR_W-1:0] a);
        return a inside {ADDR_RSVD_0, ADDR_RSVD_1, ADDR_RSVD_2, ADDR_RSVD_3};
    endfunction : is_rsvd

    logic size_ok;
    logic [15:0] any_force;
    assign size_ok = CMD_WORD ? (CMD_CODE == CMD_OVERRIDE || CMD_CODE == CMD_CRC
        || CMD_CODE == CMD_SIM) : (CMD_CODE == CMD_ADDR);
    assign any_force = SIM_FORCE[0] | SIM_FORCE[1] | SIM_FORCE[2] | SIM_FORCE[3];

    sequence addr_wr_s;
        CMD_VALID && CMD_WRITE && !CMD_WORD && CMD_CODE == CMD_ADDR && !RESTORE_REQ
            && !is_rsvd(CMD_WDATA[6:0]);
    endsequence
    sequence probe_new_s;
        ADDR_STROBE && !RESTORE_REQ && ADDR_IN == $past(CMD_WDATA[6:0]);
    endsequence
    sequence sim_wr_s;
        CMD_VALID && CMD_WRITE && CMD_WORD && CMD_CODE == CMD_SIM && CMD_PHASE == 2'h0
            && CONV_EN;
    endsequence

    read_answer_a: assert property (
        CMD_VALID && !CMD_WRITE && size_ok |=> CMD_RVALID && !CMD_NACK)
        else $error("read not answered");
    bad_access_a: assert property (
        CMD_VALID && (!size_ok || (CMD_WRITE && CMD_CODE == CMD_CRC))
        |=> CMD_NACK && !CMD_RVALID)
        else $error("bad access not refused");
    write_quiet_a: assert property (
        CMD_VALID && CMD_WRITE && size_ok && CMD_CODE != CMD_CRC
        |=> !CMD_RVALID && !CMD_NACK)
        else $error("write gave a pulse");
    addr_msb_a: assert property (
        CMD_RVALID && $past(CMD_CODE) == CMD_ADDR |-> CMD_RDATA[15:7] == 9'h000)
        else $error("address top bit set");
    addr_switch_a: assert property (
        addr_wr_s ##1 probe_new_s |=> ADDR_ACK)
        else $error("new address not answered");
    probe_answer_a: assert property (
        ADDR_STROBE |=> ADDR_ACK != ADDR_NACK)
        else $error("probe answer wrong");
    probe_quiet_a: assert property (
        !ADDR_STROBE |=> !ADDR_ACK && !ADDR_NACK)
        else $error("unrequested probe answer");
    rsvd_refuse_a: assert property (
        ADDR_STROBE && is_rsvd(ADDR_IN) |=> ADDR_NACK)
        else $error("reserved address answered");
    crc_start_a: assert property (
        (STORE_DONE || RESTORE_REQ) |-> ##2 CRC_BUSY)
        else $error("checksum walk not started");
    sim_rsvd_a: assert property (
        (any_force & ~(SIM_FAULT_MASK | SIM_WARN_MASK)) == 16'h0000)
        else $error("reserved bit forced");
    sim_off_a: assert property (
        !CONV_EN [*3] |-> (any_force & ~SIM_OFFCONV_MASK) == 16'h0000)
        else $error("force while disabled");
    sim_apply_a: assert property (
        sim_wr_s ##1 (CONV_EN && FAULT_RESP == 4'h0 && WARN_RESP == 4'h0)
        |=> SIM_FORCE[0] == ($past(CMD_WDATA, 2) & (SIM_FAULT_MASK | SIM_WARN_MASK)))
        else $error("force mismatch");
endmodule : cacs_chk

bind cacs_top cacs_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .CMD_VALID(CMD_VALID),
    .CMD_WRITE(CMD_WRITE), .CMD_WORD(CMD_WORD), .CMD_CODE(CMD_CODE), .CMD_PHASE(CMD_PHASE),
    .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
    .CMD_NACK(CMD_NACK), .ADDR_STROBE(ADDR_STROBE), .ADDR_IN(ADDR_IN), .ADDR_ACK(ADDR_ACK),
    .ADDR_NACK(ADDR_NACK), .RESTORE_REQ(RESTORE_REQ), .STORE_DONE(STORE_DONE),
    .CRC_BUSY(CRC_BUSY), .CONV_EN(CONV_EN), .FAULT_RESP(FAULT_RESP),
    .WARN_RESP(WARN_RESP), .SIM_FORCE(SIM_FORCE));

// ### tb/cacs_nvm_model.sv
// Settings memory model for the checksum walk.
// Assumes contents are a fixed function of word address and a generation byte.
`timescale 1ns/1ps
module cacs_nvm_model
    import cacs_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] gen,
    input wire logic [NVM_AW-1:0] raddr,
    output logic [15:0] rdata
);
    // One clock of read latency
    always_ff @(posedge clk) begin
        rdata <= {3'h0, raddr, gen} ^ {gen, 3'h0, raddr} ^ 16'h5a3c;
    end
endmodule : cacs_nvm_model

// ### tb/tb.sv
// Self-checking bench for the configuration register block.
// Assumes the bound checker and the settings memory model.
`timescale 1ns/1ps
module tb
    import cacs_pkg::*;
;
    logic SYS_CLK, RST, CMD_VALID, CMD_WRITE, CMD_WORD, ADDR_STROBE, RESTORE_REQ;
    logic STORE_DONE, CONV_EN, CMD_RVALID, CMD_NACK, ADDR_ACK, ADDR_NACK, CRC_BUSY;
    logic [7:0] CMD_CODE, gen;
    logic [PHASE_W-1:0] CMD_PHASE;
    logic [15:0] CMD_WDATA, CMD_RDATA, NVM_OVERRIDE, NVM_RDATA;
    logic [ADDR_W-1:0] ADDR_IN, NVM_ADDR;
    logic [NVM_AW-1:0] NVM_RADDR;
    logic [NUM_PHASES-1:0] FAULT_RESP, WARN_RESP;
    cacs_sim_t SIM_FORCE;
    logic [15:0] pv[7], nv[7], q[7], sv[4];
    logic [6:0] rs[4] = '{ADDR_RSVD_0, ADDR_RSVD_1, ADDR_RSVD_2, ADDR_RSVD_3};
    logic [9:0] bad[7] = '{{2'b01, CMD_ADDR}, {2'b11, CMD_ADDR}, {2'b11, CMD_CRC},
        {2'b00, CMD_CRC}, {2'b10, CMD_SIM}, {2'b00, CMD_OVERRIDE}, {2'b01, 8'h00}};
    logic [31:0] r;
    int err_count, n_compared;

    cacs_nvm_model u_nvm (.clk(SYS_CLK), .gen(gen), .raddr(NVM_RADDR), .rdata(NVM_RDATA));
    cacs_top dut (.SYS_CLK(SYS_CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_WRITE(CMD_WRITE),
        .CMD_WORD(CMD_WORD), .CMD_CODE(CMD_CODE), .CMD_PHASE(CMD_PHASE),
        .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
        .CMD_NACK(CMD_NACK), .ADDR_STROBE(ADDR_STROBE), .ADDR_IN(ADDR_IN),
        .ADDR_ACK(ADDR_ACK), .ADDR_NACK(ADDR_NACK), .RESTORE_REQ(RESTORE_REQ),
        .STORE_DONE(STORE_DONE), .NVM_OVERRIDE(NVM_OVERRIDE), .NVM_ADDR(NVM_ADDR),
        .NVM_RADDR(NVM_RADDR), .NVM_RDATA(NVM_RDATA), .CRC_BUSY(CRC_BUSY),
        .PIN_OC_FAULT(pv[0]), .NVM_OC_FAULT(nv[0]), .PIN_OC_WARN(pv[1]),
        .NVM_OC_WARN(nv[1]), .PIN_SW_RATE(pv[2]), .NVM_SW_RATE(nv[2]),
        .PIN_OUTPUT_VOLTAGE_SOURCE_TARGET(pv[3]), .NVM_OUTPUT_VOLTAGE_SOURCE_TARGET(nv[3]), .PIN_LOOP_SCALE(pv[4]),
        .NVM_LOOP_SCALE(nv[4]), .PIN_OUTPUT_VOLTAGE_SOURCE_CEIL(pv[5]), .NVM_OUTPUT_VOLTAGE_SOURCE_CEIL(nv[5]),
        .PIN_OUTPUT_VOLTAGE_SOURCE_FLOOR(pv[6]), .NVM_OUTPUT_VOLTAGE_SOURCE_FLOOR(nv[6]), .OVERCURRENT_FAULT_THRESHOLD(q[0]),
        .OVERCURRENT_WARNING_THRESHOLD(q[1]), .SWITCHING_RATE(q[2]),
        .OUTPUT_VOLTAGE_TARGET(q[3]), .OUTPUT_LOOP_SCALE(q[4]),
        .OUTPUT_VOLTAGE_CEILING(q[5]), .OUTPUT_VOLTAGE_FLOOR(q[6]), .CONV_EN(CONV_EN),
        .FAULT_RESP(FAULT_RESP), .WARN_RESP(WARN_RESP), .SIM_FORCE(SIM_FORCE));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : nxt
    function automatic logic [15:0] crc_of(input logic [7:0] g);
        logic [15:0] c, w;
        c = CRC_INIT;
        for (int a = 0; a < 32; a++) begin
            w = {3'h0, a[4:0], g} ^ {g, 3'h0, a[4:0]} ^ 16'h5a3c;
            for (int b = 15; b >= 0; b--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? CRC_POLY : 16'h0);
            end
        end
        return c;
    endfunction : crc_of
    function automatic logic [15:0] pick(input int i, input logic [2:0] o);
        return o[i < 2 ? OVR_OC_BIT : (i == 2 ? OVR_SWITCHING_RATE_SOURCE_BIT : OVR_OUTPUT_VOLTAGE_SOURCE_BIT)] ? pv[i] : nv[i];
    endfunction : pick
    function automatic logic [15:0] simx(input logic [15:0] v, input logic en, input logic hit);
        logic [15:0] k;
        k = v & ~(hit && !v[15] ? SIM_FAULT_MASK : 16'h0);
        k = k & ~(hit && !v[7] ? SIM_WARN_MASK : 16'h0);
        return k & (en ? (SIM_FAULT_MASK | SIM_WARN_MASK) : SIM_OFFCONV_MASK);
    endfunction : simx

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    task check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task put(input logic wr, input logic wd, input logic [7:0] c, input logic [15:0] d,
        input logic [1:0] ph);
        @(posedge SYS_CLK);
        CMD_VALID <= 1'b1;
        CMD_WRITE <= wr;
        CMD_WORD <= wd;
        CMD_CODE <= c;
        CMD_WDATA <= d;
        CMD_PHASE <= ph;
    endtask : put
    task cmd(input logic wr, input logic wd, input logic [7:0] c, input logic [15:0] d,
        input logic [1:0] ph);
        put(wr, wd, c, d, ph);
        @(posedge SYS_CLK);
        CMD_VALID <= 1'b0;
        #1;
    endtask : cmd
    task rd(input logic [7:0] c, input logic wd, input logic [1:0] ph, input logic [15:0] e);
        cmd(1'b0, wd, c, 16'h0, ph);
        check({14'h0, CMD_RVALID, CMD_NACK}, 16'h0002);
        check(CMD_RDATA, e);
    endtask : rd
    // Address write, then a probe on the very next cycle
    task wa(input logic [7:0] d, input logic [6:0] p, input logic ack);
        put(1'b1, 1'b0, CMD_ADDR, {8'h00, d}, 2'h0);
        @(posedge SYS_CLK);
        CMD_VALID <= 1'b0;
        ADDR_STROBE <= 1'b1;
        ADDR_IN <= p;
        @(posedge SYS_CLK);
        ADDR_STROBE <= 1'b0;
        #1;
        check({14'h0, ADDR_ACK, ADDR_NACK}, {14'h0, ack, !ack});
    endtask : wa
    task crcwait;
        repeat (3) @(posedge SYS_CLK);
        for (int i = 0; i < 200 && CRC_BUSY !== 1'b0; i++) @(posedge SYS_CLK);
    endtask : crcwait
    task pulse(input logic st, input logic rq, input logic [3:0] rsp);
        @(posedge SYS_CLK);
        STORE_DONE <= st;
        RESTORE_REQ <= rq;
        FAULT_RESP <= rsp;
        WARN_RESP <= rsp;
        @(posedge SYS_CLK);
        {STORE_DONE, RESTORE_REQ, FAULT_RESP, WARN_RESP} <= 10'h0;
        @(posedge SYS_CLK);
        #1;
    endtask : pulse

    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        err_count++;
        conclude();
    end
    initial begin
        {RST, CMD_VALID, CMD_WRITE, CMD_WORD, ADDR_STROBE, RESTORE_REQ, STORE_DONE} = 7'h40;
        {CMD_CODE, CMD_PHASE, CMD_WDATA, ADDR_IN, FAULT_RESP, WARN_RESP} = '0;
        {CONV_EN, gen, NVM_OVERRIDE, NVM_ADDR} = {1'b1, 8'h11, 16'h0005, 7'h22};
        r = 32'h6690ff6f;
        for (int i = 0; i < 7; i++) begin
            r = nxt(r);
            {pv[i], nv[i]} = r;
        end
        repeat (10) @(posedge SYS_CLK);
        RST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1;
        for (int i = 0; i < 7; i++) begin
            check(q[i], pick(i, 3'h5));
        end
        crcwait();
        rd(CMD_CRC, 1'b1, 2'h0, crc_of(8'h11));
        gen <= 8'h3c;
        pulse(1'b1, 1'b0, 4'h0);
        crcwait();
        rd(CMD_CRC, 1'b1, 2'h0, crc_of(8'h3c));
        // Restores below must recompute over a changed memory image
        gen <= 8'h5a;
        for (int o = 0; o < 8; o++) begin
            @(posedge SYS_CLK);
            NVM_OVERRIDE <= o[15:0];
            cmd(1'b1, 1'b1, CMD_OVERRIDE, o[15:0], 2'h0);
            pulse(1'b0, 1'b1, 4'h0);
            for (int i = 0; i < 7; i++) begin
                check(q[i], pick(i, o[2:0]));
            end
            rd(CMD_OVERRIDE, 1'b1, 2'h0, o[15:0]);
        end
        crcwait();
        rd(CMD_CRC, 1'b1, 2'h0, crc_of(8'h5a));
        rd(CMD_ADDR, 1'b0, 2'h0, 16'h0022);
        wa(8'hd0, 7'h22, 1'b0);
        rd(CMD_ADDR, 1'b0, 2'h0, 16'h0050);
        for (int k = 0; k < 4; k++) begin
            wa({1'b0, rs[k]}, 7'h50, 1'b1);
            wa(8'h50, rs[k], 1'b0);
        end
        repeat (6) begin
            r = nxt(r);
            if (!(r[6:0] inside {ADDR_RSVD_0, ADDR_RSVD_1, ADDR_RSVD_2, ADDR_RSVD_3}))
                wa({1'b0, r[6:0]}, r[6:0], 1'b1);
        end
        for (int k = 0; k < 7; k++) begin
            cmd(bad[k][9], bad[k][8], bad[k][7:0], 16'hffff, 2'h0);
            check({14'h0, CMD_RVALID, CMD_NACK}, 16'h0001);
        end
        for (int p = 0; p < 4; p++) begin
            r = nxt(r);
            sv[p] = r[15:0];
        end
        sv[0] = (sv[0] | 16'h1010) & 16'hff7f & 16'h7fff;
        sv[1] = sv[1] | 16'h8080;
        for (int p = 0; p < 4; p++) cmd(1'b1, 1'b1, CMD_SIM, sv[p], p[1:0]);
        @(posedge SYS_CLK);
        #1;
        for (int p = 0; p < 4; p++) begin
            check(SIM_FORCE[p], simx(sv[p], 1'b1, 1'b0));
        end
        for (int p = 0; p < 4; p++) rd(CMD_SIM, 1'b1, p[1:0], sv[p]);
        pulse(1'b0, 1'b0, 4'h3);
        @(posedge SYS_CLK);
        #1;
        for (int p = 0; p < 4; p++) begin
            check(SIM_FORCE[p], simx(sv[p], 1'b1, p < 2));
        end
        @(posedge SYS_CLK);
        CONV_EN <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        #1;
        for (int p = 1; p < 4; p++) begin
            check(SIM_FORCE[p], simx(sv[p], 1'b0, 1'b0));
        end
        conclude();
    end
endmodule : tb
